// >>> logic/adcr_defines.svh
`ifndef ADCR_DEFINES_SVH
`define ADCR_DEFINES_SVH

// register offsets on the control port
`define ADCR_OFF_CH3_IMAG     8'h2C
`define ADCR_OFF_CH4_REAL     8'h2D
`define ADCR_OFF_CH4_IMAG     8'h2E
`define ADCR_OFF_SPK_FLAGS    8'h2F
`define ADCR_OFF_MISC3        8'h30
`define ADCR_OFF_REVISION     8'h32
`define ADCR_OFF_FOLDBACK     8'h33

// reset values
`define ADCR_RST_REPORT       8'h00
`define ADCR_RST_MISC3        7'h00
`define ADCR_RST_FOLDBACK     8'h00
`define ADCR_UNMAPPED_DATA    8'h00

// misc_control_three fields
`define ADCR_MISC_FLTCLR_BIT  7
`define ADCR_MISC_SETTLE_HI   5
`define ADCR_MISC_SETTLE_LO   4
`define ADCR_MISC_OTREC_BIT   3
`define ADCR_MISC_PULLUP_BIT  1

// thermal_foldback_control fields
`define ADCR_FB_WAIT_HI       7
`define ADCR_FB_WAIT_LO       6
`define ADCR_FB_BYPASS_BIT    5
`define ADCR_FB_ZCSKIP_BIT    4
`define ADCR_FB_ATTACK_HI     3
`define ADCR_FB_ATTACK_LO     2
`define ADCR_FB_RELEASE_HI    1
`define ADCR_FB_RELEASE_LO    0

// gain reduction limit in dB steps
`define ADCR_GAIN_RED_MAX     4'hF

// timing: clock rate and documented times
`define ADCR_CLK_KHZ          125000
`define ADCR_TMR_W            28
`define ADCR_SETTLE0_MS       20
`define ADCR_SETTLE1_MS       15
`define ADCR_SETTLE2_MS       40
`define ADCR_SETTLE3_MS       50
`define ADCR_STEPWAIT0_US     20
`define ADCR_STEPWAIT1_US     80
`define ADCR_STEPWAIT2_US     320
`define ADCR_STEPWAIT3_US     1280
`define ADCR_ATTACK0_MS       100
`define ADCR_ATTACK1_MS       200
`define ADCR_ATTACK2_MS       400
`define ADCR_ATTACK3_MS       800
`define ADCR_RELEASE0_MS      200
`define ADCR_RELEASE1_MS      400
`define ADCR_RELEASE2_MS      800
`define ADCR_RELEASE3_MS      1600

`endif

// >>> logic/adcr_pkg.sv
`default_nettype none
package adcr_pkg;

    // register port request from the serial control engine
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adcr_reg_req_t;

    // one finished impedance measurement
    typedef struct packed {
        logic       valid;
        logic [1:0] chan;
        logic [7:0] realPart;
        logic [7:0] imagPart;
    } adcr_meas_t;

    // small speaker judgement settings held elsewhere in the map
    typedef struct packed {
        logic       judgeEnable;
        logic       realOnly;
        logic [7:0] threshold;
    } adcr_judge_cfg_t;

    typedef enum logic [1:0] {
        FB_IDLE,
        FB_PERIOD,
        FB_WAIT,
        FB_ZC
    } adcr_fb_state_t;

    typedef struct packed {
        logic [27:0] count;
        logic        busy;
        logic        done;
    } adcr_tmr_state_t;

    typedef struct packed {
        logic           otMeta;
        logic           otSync;
        logic           warnMeta;
        logic           warnSync;
        logic           zcMeta;
        logic           zcSync;
        logic           zcPrev;
        logic [7:0]     ch3Imag;
        logic [7:0]     ch4Real;
        logic [7:0]     ch4Imag;
        logic [3:0]     flags;
        logic [6:0]     miscCtl;
        logic [7:0]     fbCtl;
        logic [7:0]     rdData;
        logic           faultClear;
        logic           faultLatched;
        logic           thermShut;
        logic           settleDone;
        logic           pullUpEn;
        adcr_fb_state_t fbState;
        logic           fbDown;
        logic [3:0]     gainRed;
    } adcr_state_t;

endpackage
`default_nettype wire

// >>> logic/adcr_interval_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "adcr_defines.svh"
module adcr_interval_timer (
    input  wire logic                    clk,
    input  wire logic                    rstN,
    input  wire logic                    start,
    input  wire logic [`ADCR_TMR_W-1:0]  loadCount,
    output logic                         busy,
    output logic                         done
);
    adcr_pkg::adcr_tmr_state_t s_reg;
    adcr_pkg::adcr_tmr_state_t s_next;

    // a start while busy restarts the interval
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (start) begin
            s_next.count = loadCount;
            s_next.busy = 1'b1;
        end else if (s_reg.busy) begin
            if (s_reg.count <= `ADCR_TMR_W'(1)) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                s_next.count = '0;
            end else begin
                s_next.count = s_reg.count - `ADCR_TMR_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy = s_reg.busy;
    assign done = s_reg.done;
endmodule
`default_nettype wire

// >>> logic/adcr_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "adcr_defines.svh"
// Operation
// - imaginary reports hold the complement of the measured imaginary part
// - real reports hold the measured real part, read-only, eight bits
// - one small-speaker flag per channel, channel 1 at bit 3
// - writing 1 to bit 7 of misc control clears latched faults
// - startup settle wait of 20, 15, 40 or 50 ms by field
// - thermal shutdown self-releases only when the recovery bit is set
// - open-drain pin pull-up enabled while bit 1 is zero
// - wait 20, 80, 320 or 1280 us before every gain step
// - foldback bypass bit 5 disables thermal gain reduction entirely
// - bit 4 skips the zero crossing wait for gain changes
// - judged magnitude below threshold sets the channel's small-speaker flag
module adcr_regs #(
    parameter logic [`ADCR_TMR_W-1:0] SETTLE_CYC0  = `ADCR_TMR_W'(`ADCR_SETTLE0_MS * `ADCR_CLK_KHZ),
    parameter logic [`ADCR_TMR_W-1:0] SETTLE_CYC1  = `ADCR_TMR_W'(`ADCR_SETTLE1_MS * `ADCR_CLK_KHZ),
    parameter logic [`ADCR_TMR_W-1:0] SETTLE_CYC2  = `ADCR_TMR_W'(`ADCR_SETTLE2_MS * `ADCR_CLK_KHZ),
    parameter logic [`ADCR_TMR_W-1:0] SETTLE_CYC3  = `ADCR_TMR_W'(`ADCR_SETTLE3_MS * `ADCR_CLK_KHZ),
    parameter logic [`ADCR_TMR_W-1:0] STEPWAIT_CYC1
        = `ADCR_TMR_W'(`ADCR_STEPWAIT1_US * `ADCR_CLK_KHZ / 1000),
    parameter logic [`ADCR_TMR_W-1:0] STEPWAIT_CYC2
        = `ADCR_TMR_W'(`ADCR_STEPWAIT2_US * `ADCR_CLK_KHZ / 1000),
    parameter logic [`ADCR_TMR_W-1:0] STEPWAIT_CYC3
        = `ADCR_TMR_W'(`ADCR_STEPWAIT3_US * `ADCR_CLK_KHZ / 1000),
    parameter logic [`ADCR_TMR_W-1:0] ATTACK_CYC0  = `ADCR_TMR_W'(`ADCR_ATTACK0_MS * `ADCR_CLK_KHZ),
    parameter logic [`ADCR_TMR_W-1:0] ATTACK_CYC1  = `ADCR_TMR_W'(`ADCR_ATTACK1_MS * `ADCR_CLK_KHZ),
    parameter logic [`ADCR_TMR_W-1:0] ATTACK_CYC2  = `ADCR_TMR_W'(`ADCR_ATTACK2_MS * `ADCR_CLK_KHZ),
    parameter logic [`ADCR_TMR_W-1:0] ATTACK_CYC3  = `ADCR_TMR_W'(`ADCR_ATTACK3_MS * `ADCR_CLK_KHZ),
    parameter logic [`ADCR_TMR_W-1:0] RELEASE_CYC0 = `ADCR_TMR_W'(`ADCR_RELEASE0_MS * `ADCR_CLK_KHZ),
    parameter logic [`ADCR_TMR_W-1:0] RELEASE_CYC1 = `ADCR_TMR_W'(`ADCR_RELEASE1_MS * `ADCR_CLK_KHZ),
    parameter logic [`ADCR_TMR_W-1:0] RELEASE_CYC2 = `ADCR_TMR_W'(`ADCR_RELEASE2_MS * `ADCR_CLK_KHZ),
    parameter logic [`ADCR_TMR_W-1:0] RELEASE_CYC3 = `ADCR_TMR_W'(`ADCR_RELEASE3_MS * `ADCR_CLK_KHZ),
    parameter logic [7:0]             REV_CODE     = 8'h5A  // arbitrary value
) (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire adcr_pkg::adcr_reg_req_t   regReq,
    output logic [7:0]                     regRdData,
    input  wire adcr_pkg::adcr_meas_t      meas,
    input  wire adcr_pkg::adcr_judge_cfg_t judgeCfg,
    input  wire logic                      faultEvent,
    input  wire logic                      overTempPin,
    input  wire logic                      thermalWarnPin,
    input  wire logic                      zeroCrossPin,
    input  wire logic                      startupReq,
    output logic                           settleDone,
    output logic                           faultClear,
    output logic                           faultLatched,
    output logic                           thermalShutdown,
    output logic                           pullUpEnable,
    output logic [3:0]                     gainReduction
);
    // below the parameter threshold, so a fixed count
    localparam logic [`ADCR_TMR_W-1:0] STEPWAIT_CYC0
        = `ADCR_TMR_W'(`ADCR_STEPWAIT0_US * `ADCR_CLK_KHZ / 1000);

    logic                   rstMeta;
    logic                   rstN;
    adcr_pkg::adcr_state_t  s_reg;
    adcr_pkg::adcr_state_t  s_next;
    logic                   startSettle;
    logic                   startPeriod;
    logic                   startWait;
    logic [`ADCR_TMR_W-1:0] settleCount;
    logic [`ADCR_TMR_W-1:0] periodCount;
    logic [`ADCR_TMR_W-1:0] waitCount;
    logic                   settleTmrDone;
    logic                   periodTmrDone;
    logic                   waitTmrDone;
    logic                   clrWrite;
    logic                   zcRise;
    logic                   needStep;
    logic                   stepDown;

    // pick one of four cycle counts by a two-bit code
    function automatic logic [`ADCR_TMR_W-1:0] selCount(
        input logic [1:0]             code,
        input logic [`ADCR_TMR_W-1:0] c0,
        input logic [`ADCR_TMR_W-1:0] c1,
        input logic [`ADCR_TMR_W-1:0] c2,
        input logic [`ADCR_TMR_W-1:0] c3
    );
        logic [`ADCR_TMR_W-1:0] r;
        case (code)
            2'h0: r = c0;
            2'h1: r = c1;
            2'h2: r = c2;
            default: r = c3;
        endcase
        return r;
    endfunction

    // judged magnitude is real part, or real plus half imaginary
    function automatic logic [8:0] judgeMag(
        input logic       realOnly,
        input logic [7:0] re,
        input logic [7:0] im
    );
        logic [8:0] m;
        m = realOnly ? {1'b0, re} : ({1'b0, re} + {2'h0, im[7:1]});
        return m;
    endfunction

    // read decode; unmapped and write-only locations read as zero
    function automatic logic [7:0] readMux(
        input adcr_pkg::adcr_state_t st,
        input logic [7:0]            addr
    );
        logic [7:0] d;
        if (addr == `ADCR_OFF_CH3_IMAG) begin
            d = st.ch3Imag;
        end else if (addr == `ADCR_OFF_CH4_REAL) begin
            d = st.ch4Real;
        end else if (addr == `ADCR_OFF_CH4_IMAG) begin
            d = st.ch4Imag;
        end else if (addr == `ADCR_OFF_SPK_FLAGS) begin
            d = {4'h0, st.flags};
        end else if (addr == `ADCR_OFF_MISC3) begin
            d = {1'b0, st.miscCtl};  // clear bit is write-only
        end else if (addr == `ADCR_OFF_REVISION) begin
            d = REV_CODE;
        end else if (addr == `ADCR_OFF_FOLDBACK) begin
            d = st.fbCtl;
        end else begin
            d = `ADCR_UNMAPPED_DATA;
        end
        return d;
    endfunction

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // interval counts chosen from the live register fields
    assign settleCount = selCount(s_reg.miscCtl[`ADCR_MISC_SETTLE_HI:`ADCR_MISC_SETTLE_LO],
                                  SETTLE_CYC0, SETTLE_CYC1, SETTLE_CYC2, SETTLE_CYC3);
    assign waitCount = selCount(s_reg.fbCtl[`ADCR_FB_WAIT_HI:`ADCR_FB_WAIT_LO],
                                STEPWAIT_CYC0, STEPWAIT_CYC1,
                                STEPWAIT_CYC2, STEPWAIT_CYC3);
    assign periodCount = stepDown
        ? selCount(s_reg.fbCtl[`ADCR_FB_ATTACK_HI:`ADCR_FB_ATTACK_LO],
                   ATTACK_CYC0, ATTACK_CYC1, ATTACK_CYC2, ATTACK_CYC3)
        : selCount(s_reg.fbCtl[`ADCR_FB_RELEASE_HI:`ADCR_FB_RELEASE_LO],
                   RELEASE_CYC0, RELEASE_CYC1, RELEASE_CYC2, RELEASE_CYC3);

    // warning calls for more reduction, its absence for less
    assign stepDown = s_reg.warnSync;
    assign needStep = s_reg.warnSync ? (s_reg.gainRed != `ADCR_GAIN_RED_MAX)
                                     : (s_reg.gainRed != 4'h0);
    assign zcRise = s_reg.zcSync & ~s_reg.zcPrev;
    assign clrWrite = regReq.write && (regReq.addr == `ADCR_OFF_MISC3)
                      && regReq.wdata[`ADCR_MISC_FLTCLR_BIT];

    // next-state logic for the whole block
    always_comb begin
        s_next = s_reg;
        startSettle = 1'b0;
        startPeriod = 1'b0;
        startWait = 1'b0;

        // pin synchronisers; first stage feeds only the second
        s_next.otMeta = overTempPin;
        s_next.otSync = s_reg.otMeta;
        s_next.warnMeta = thermalWarnPin;
        s_next.warnSync = s_reg.warnMeta;
        s_next.zcMeta = zeroCrossPin;
        s_next.zcSync = s_reg.zcMeta;
        s_next.zcPrev = s_reg.zcSync;

        // register writes; report registers ignore writes
        s_next.faultClear = clrWrite;
        if (regReq.write) begin
            if (regReq.addr == `ADCR_OFF_MISC3) begin
                s_next.miscCtl = regReq.wdata[6:0];
            end else if (regReq.addr == `ADCR_OFF_FOLDBACK) begin
                s_next.fbCtl = regReq.wdata;
            end
        end
        if (regReq.read) begin
            s_next.rdData = readMux(s_reg, regReq.addr);
        end

        // measurement results land in the reports, flags judged at once
        if (meas.valid) begin
            if (meas.chan == 2'h2) begin
                s_next.ch3Imag = ~meas.imagPart;
            end else if (meas.chan == 2'h3) begin
                s_next.ch4Real = meas.realPart;
                s_next.ch4Imag = ~meas.imagPart;
            end
            if (judgeCfg.judgeEnable) begin
                s_next.flags[~meas.chan] = judgeMag(judgeCfg.realOnly, meas.realPart,
                    meas.imagPart) < {1'b0, judgeCfg.threshold};
            end
        end

        // thermal shutdown: entry always wins over any release
        if (s_reg.otSync) begin
            s_next.thermShut = 1'b1;
        end else if (s_reg.miscCtl[`ADCR_MISC_OTREC_BIT] || clrWrite) begin
            s_next.thermShut = 1'b0;
        end

        // fault latch: a new fault in the clear cycle is kept
        if (faultEvent || s_reg.otSync) begin
            s_next.faultLatched = 1'b1;
        end else if (clrWrite) begin
            s_next.faultLatched = 1'b0;
        end

        // startup settle interval
        startSettle = startupReq;
        s_next.settleDone = settleTmrDone;
        s_next.pullUpEn = ~s_reg.miscCtl[`ADCR_MISC_PULLUP_BIT];

        // foldback sequencer: period, then wait, then optional zero crossing
        case (s_reg.fbState)
            adcr_pkg::FB_IDLE: begin
                if (needStep) begin
                    startPeriod = 1'b1;
                    s_next.fbDown = stepDown;
                    s_next.fbState = adcr_pkg::FB_PERIOD;
                end
            end
            adcr_pkg::FB_PERIOD: begin
                // abandon the period if the warning flips direction
                if (!needStep || (stepDown != s_reg.fbDown)) begin
                    s_next.fbState = adcr_pkg::FB_IDLE;
                end else if (periodTmrDone) begin
                    startWait = 1'b1;
                    s_next.fbState = adcr_pkg::FB_WAIT;
                end
            end
            adcr_pkg::FB_WAIT: begin
                if (waitTmrDone) begin
                    if (s_reg.fbCtl[`ADCR_FB_ZCSKIP_BIT]) begin
                        s_next.gainRed = s_reg.fbDown ? s_reg.gainRed + 4'h1
                                                      : s_reg.gainRed - 4'h1;
                        s_next.fbState = adcr_pkg::FB_IDLE;
                    end else begin
                        s_next.fbState = adcr_pkg::FB_ZC;
                    end
                end
            end
            adcr_pkg::FB_ZC: begin
                if (zcRise) begin
                    s_next.gainRed = s_reg.fbDown ? s_reg.gainRed + 4'h1
                                                  : s_reg.gainRed - 4'h1;
                    s_next.fbState = adcr_pkg::FB_IDLE;
                end
            end
            default: begin
                s_next.fbState = adcr_pkg::FB_IDLE;
            end
        endcase

        // bypass forces unity gain and parks the sequencer
        if (s_reg.fbCtl[`ADCR_FB_BYPASS_BIT]) begin
            s_next.gainRed = 4'h0;
            s_next.fbState = adcr_pkg::FB_IDLE;
            startPeriod = 1'b0;
            startWait = 1'b0;
        end
    end

    // single state register for the block
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s_reg <= '0;
            s_reg.ch3Imag <= `ADCR_RST_REPORT;
            s_reg.ch4Real <= `ADCR_RST_REPORT;
            s_reg.ch4Imag <= `ADCR_RST_REPORT;
            s_reg.miscCtl <= `ADCR_RST_MISC3;
            s_reg.fbCtl <= `ADCR_RST_FOLDBACK;
            s_reg.pullUpEn <= 1'b1;
            s_reg.fbState <= adcr_pkg::FB_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    adcr_interval_timer settleTmr (
        .clk       (clk),
        .rstN      (rstN),
        .start     (startSettle),
        .loadCount (settleCount),
        .busy      (),
        .done      (settleTmrDone)
    );

    adcr_interval_timer periodTmr (
        .clk       (clk),
        .rstN      (rstN),
        .start     (startPeriod),
        .loadCount (periodCount),
        .busy      (),
        .done      (periodTmrDone)
    );

    adcr_interval_timer waitTmr (
        .clk       (clk),
        .rstN      (rstN),
        .start     (startWait),
        .loadCount (waitCount),
        .busy      (),
        .done      (waitTmrDone)
    );

    // outputs straight from the state register
    assign regRdData = s_reg.rdData;
    assign settleDone = s_reg.settleDone;
    assign faultClear = s_reg.faultClear;
    assign faultLatched = s_reg.faultLatched;
    assign thermalShutdown = s_reg.thermShut;
    assign pullUpEnable = s_reg.pullUpEn;
    assign gainReduction = s_reg.gainRed;
endmodule
`default_nettype wire

// >>> bench/adcr_regs_props.sv
`timescale 1ns/1ns
`default_nettype none
module adcr_regs_props #(
    parameter logic [7:0] REV_CODE = 8'h00  // arbitrary value
) (
    input wire logic                    clk,
    input wire logic                    nrst,
    input wire adcr_pkg::adcr_reg_req_t regReq,
    input wire logic [7:0]              regRdData,
    input wire adcr_pkg::adcr_meas_t    meas,
    input wire logic                    overTempPin,
    input wire logic                    faultClear,
    input wire logic                    thermalShutdown,
    input wire logic                    pullUpEnable,
    input wire logic [3:0]              gainReduction
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // building blocks: misc write, channel 4 result, a clean read
    sequence s_misc_wr;
        regReq.write && regReq.addr == 8'h30;
    endsequence
    sequence s_meas4;
        meas.valid && meas.chan == 2'h3;
    endsequence
    sequence s_rd(logic [7:0] a);
        regReq.read && regReq.addr == a && !meas.valid;
    endsequence

    property p_clr_pulse;
        (s_misc_wr ##0 regReq.wdata[7]) |=> faultClear;
    endproperty
    property p_clr_cause;
        faultClear |-> $past(regReq.write && regReq.addr == 8'h30 && regReq.wdata[7]);
    endproperty
    // pull-up may lag one extra cycle behind the stored bit
    property p_pull;
        s_misc_wr |-> ##2 pullUpEnable == !$past(regReq.wdata[1], 2);
    endproperty
    property p_imag;
        s_meas4 ##1 s_rd(8'h2E) |=> regRdData == ~$past(meas.imagPart, 2);
    endproperty
    property p_real;
        s_meas4 ##1 s_rd(8'h2D) |=> regRdData == $past(meas.realPart, 2);
    endproperty
    property p_rev;
        s_rd(8'h32) |=> regRdData == REV_CODE;
    endproperty
    // two sync flops plus the output register
    property p_ot_set;
        $rose(overTempPin) |-> ##3 thermalShutdown;
    endproperty
    property p_ot_hold;
        thermalShutdown && overTempPin |=> thermalShutdown;
    endproperty
    property p_bypass;
        regReq.write && regReq.addr == 8'h33 && regReq.wdata[5] |-> ##2 gainReduction == 4'h0;
    endproperty
    property p_step;
        $changed(gainReduction) |-> gainReduction == 4'h0
            || gainReduction == $past(gainReduction) + 4'h1
            || gainReduction == $past(gainReduction) - 4'h1;
    endproperty

    a_clr_pulse: assert property (p_clr_pulse) else $error("no clear pulse");
    a_clr_cause: assert property (p_clr_cause) else $error("stray clear pulse");
    a_pull: assert property (p_pull) else $error("pull-up wrong");
    a_imag: assert property (p_imag) else $error("imag report wrong");
    a_real: assert property (p_real) else $error("real report wrong");
    a_rev: assert property (p_rev) else $error("revision wrong");
    a_ot_set: assert property (p_ot_set) else $error("shutdown late");
    a_ot_hold: assert property (p_ot_hold) else $error("shutdown dropped");
    a_bypass: assert property (p_bypass) else $error("bypass ignored");
    a_step: assert property (p_step) else $error("gain jump");
endmodule

bind adcr_regs adcr_regs_props #(.REV_CODE(REV_CODE)) i_props (
    .clk(clk), .nrst(nrst), .regReq(regReq), .regRdData(regRdData), .meas(meas),
    .overTempPin(overTempPin), .faultClear(faultClear), .thermalShutdown(thermalShutdown),
    .pullUpEnable(pullUpEnable), .gainReduction(gainReduction));
`default_nettype wire

// >>> bench/adcr_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module adcr_regs_tb;
    logic                      clk;
    logic                      nrst;
    adcr_pkg::adcr_reg_req_t   req;
    adcr_pkg::adcr_meas_t      meas;
    adcr_pkg::adcr_judge_cfg_t jcfg;
    logic                      fltEv;
    logic                      otPin;
    logic                      warnPin;
    logic                      zcPin;
    logic                      start;
    logic [7:0]                rdData;
    logic                      settleDone;
    logic                      fltClr;
    logic                      fltLat;
    logic                      shut;
    logic                      pullUp;
    logic [3:0]                gain;
    int                        fail_count;
    int                        compares;
    int                        n;
    // shortened settle counts keep every code to 100 cycles or fewer
    localparam logic [27:0] SET_CYC [4] = '{28'h28, 28'h1E, 28'h50, 28'h64};
    localparam logic [7:0] REV = 8'h3C;  // arbitrary value
    localparam logic [7:0] ADDR [8] = '{8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33};
    localparam logic [7:0] AFT [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h00, REV, 8'hFF};

    adcr_regs #(.SETTLE_CYC0(SET_CYC[0]), .SETTLE_CYC1(SET_CYC[1]), .SETTLE_CYC2(SET_CYC[2]),
        .SETTLE_CYC3(SET_CYC[3]), .STEPWAIT_CYC1(28'h14), .ATTACK_CYC0(28'h3C),
        .RELEASE_CYC0(28'h3C), .REV_CODE(REV)) i_dut (
        .clk(clk), .nrst(nrst), .regReq(req), .regRdData(rdData), .meas(meas),
        .judgeCfg(jcfg), .faultEvent(fltEv), .overTempPin(otPin), .thermalWarnPin(warnPin),
        .zeroCrossPin(zcPin), .startupReq(start), .settleDone(settleDone),
        .faultClear(fltClr), .faultLatched(fltLat), .thermalShutdown(shut),
        .pullUpEnable(pullUp), .gainReduction(gain));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // all bus tasks enter and leave on a falling edge
    // spare edge between calls, so no strobe drops and rises at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req.write = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        req.write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        req.read = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.read = 1'b0;
        chk(rdData, e);
        @(negedge clk);
    endtask
    task automatic ms(input logic [1:0] c, input logic [7:0] re, input logic [7:0] im);
        meas = '{1'b1, c, re, im};
        @(negedge clk);
        meas.valid = 1'b0;
    endtask
    task automatic wg(input logic [3:0] v, input int lim);
        for (int i = 0; i < lim && gain !== v; i++) begin
            @(negedge clk);
        end
        chk({4'h0, gain}, {4'h0, v});
    endtask
    task automatic done(input string s);
        $display("test %s done at %0t", s, $time);
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog of 20000 cycles, well beyond what the tests need
    initial begin
        #(8 * 20000);
        fail_count++;
        stop_test();
    end

    initial begin
        req = '0;
        meas = '0;
        jcfg = '0;
        {fltEv, otPin, warnPin, zcPin, start} = 5'h00;
        nrst = 1'b0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h00, pullUp}, 8'h01);
        for (int i = 0; i < 8; i++) rd(ADDR[i], (i == 6) ? REV : 8'h00);
        for (int i = 0; i < 8; i++) wr(ADDR[i], 8'hFF);
        for (int i = 0; i < 8; i++) rd(ADDR[i], AFT[i]);
        chk({7'h00, pullUp}, 8'h00);
        wr(8'h30, 8'h00);
        wr(8'h33, 8'h00);
        chk({7'h00, pullUp}, 8'h01);
        done("registers");
        // measurements, judged and not
        jcfg = '{1'b1, 1'b0, 8'h20};
        ms(2'h3, 8'h10, 8'h04);
        rd(8'h2E, 8'hFB);
        rd(8'h2D, 8'h10);
        rd(8'h2F, 8'h01);
        ms(2'h2, 8'h30, 8'h33);
        rd(8'h2C, 8'hCC);
        ms(2'h0, 8'h05, 8'h00);
        rd(8'h2F, 8'h09);
        jcfg.realOnly = 1'b1;
        ms(2'h1, 8'h1F, 8'hFE);
        rd(8'h2F, 8'h0D);
        jcfg.judgeEnable = 1'b0;
        ms(2'h3, 8'h40, 8'h00);
        rd(8'h2D, 8'h40);
        rd(8'h2F, 8'h0D);
        done("measurement");
        // settle wait for every field code
        for (int c = 0; c < 4; c++) begin
            wr(8'h30, 8'(c << 4));
            start = 1'b1;
            @(negedge clk);
            start = 1'b0;
            n = 1;
            while (settleDone !== 1'b1 && n < 300) begin
                @(negedge clk);
                n++;
            end
            chk(8'(n), 8'(SET_CYC[c] + 2));
        end
        done("settle");
        // faults and over temperature with and without self restart
        fltEv = 1'b1;
        @(negedge clk);
        fltEv = 1'b0;
        wr(8'h30, 8'h08);
        chk({6'h00, fltClr, fltLat}, 8'h01);
        otPin = 1'b1;
        repeat (5) @(negedge clk);
        chk({6'h00, shut, fltLat}, 8'h03);
        otPin = 1'b0;
        repeat (5) @(negedge clk);
        chk({6'h00, shut, fltLat}, 8'h01);
        wr(8'h30, 8'h00);
        otPin = 1'b1;
        repeat (5) @(negedge clk);
        otPin = 1'b0;
        repeat (5) @(negedge clk);
        chk({6'h00, shut, fltLat}, 8'h03);
        wr(8'h30, 8'h80);
        chk({5'h00, fltClr, shut, fltLat}, 8'h04);
        done("thermal");
        // foldback: wait time, zero crossing, release, bypass
        wr(8'h33, 8'h50);
        warnPin = 1'b1;
        repeat (70) @(negedge clk);
        chk({4'h0, gain}, 8'h00);
        wg(4'h1, 100);
        wr(8'h33, 8'h40);
        repeat (300) @(negedge clk);
        chk({4'h0, gain}, 8'h01);
        zcPin = 1'b1;
        wg(4'h2, 10);
        zcPin = 1'b0;
        warnPin = 1'b0;
        wr(8'h33, 8'h50);
        wg(4'h0, 400);
        warnPin = 1'b1;
        wg(4'h1, 200);
        wr(8'h33, 8'h70);
        repeat (300) @(negedge clk);
        chk({4'h0, gain}, 8'h00);
        done("foldback");
        stop_test();
    end
endmodule
`default_nettype wire
